// ===== design/osd_decoder.sv
`include "osd_defines.svh"

module osd_decoder (
  // Clock and reset.
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  // Operation request.
  input  wire osd_pkg::osd_req_t  i_req,
  // Answer and status.
  output      osd_pkg::osd_resp_t o_resp,
  output      logic               o_busy,
  output      logic [15:0]        o_sr
);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  osd_pkg::osd_regs_t  st_q;
  osd_pkg::osd_regs_t  st_d;
  osd_pkg::osd_size_t  sz;
  osd_pkg::osd_ea_t    ea;
  osd_pkg::osd_class_t cls;
  osd_pkg::osd_resp_t  rsp;
  logic                sz_ok;
  logic                illegal;
  logic [31:0]         qa;
  logic [31:0]         qb;
  logic [31:0]         src_raw;
  logic [31:0]         src_sz;
  logic [31:0]         wr_val;
  logic [31:0]         aligned;
  logic [15:0]         sr_rd;
  logic [15:0]         sr_new;
  logic                rf_we;
  logic [2:0]          nbytes;
  logic [4:0]          shamt;
  logic [3:0][7:0]     lanes;

  // Resolves the operand size from the instruction or the operation.
  function automatic osd_pkg::osd_size_t osd_pick_size(
    input logic               expl,
    input logic [1:0]         code,
    input osd_pkg::osd_size_t impl
  );
    if (!expl)
    begin
      return impl;
    end
    case (code)
      `OSD_SZ_BYTE: return osd_pkg::OSD_BYTE;
      `OSD_SZ_WORD: return osd_pkg::OSD_WORD;
      `OSD_SZ_LONG: return osd_pkg::OSD_LONG;
      default:      return osd_pkg::OSD_BYTE;
    endcase
  endfunction : osd_pick_size

  // Maps the mode and register fields onto one of twelve modes.
  function automatic osd_pkg::osd_ea_t osd_ea_dec(
    input logic [2:0] mode,
    input logic [2:0] rg
  );
    case (mode)
      `OSD_M_DREG: return osd_pkg::OSD_EA_DREG;
      `OSD_M_AREG: return osd_pkg::OSD_EA_AREG;
      `OSD_M_IND:  return osd_pkg::OSD_EA_IND;
      `OSD_M_POST: return osd_pkg::OSD_EA_POST;
      `OSD_M_PRE:  return osd_pkg::OSD_EA_PRE;
      `OSD_M_D16:  return osd_pkg::OSD_EA_D16;
      `OSD_M_IDX:  return osd_pkg::OSD_EA_IDX;
      `OSD_M_EXT:
      begin
        case (rg)
          `OSD_X_ABSW:  return osd_pkg::OSD_EA_ABSW;
          `OSD_X_ABSL:  return osd_pkg::OSD_EA_ABSL;
          `OSD_X_PCD16: return osd_pkg::OSD_EA_PCD16;
          `OSD_X_PCIDX: return osd_pkg::OSD_EA_PCIDX;
          `OSD_X_IMM:   return osd_pkg::OSD_EA_IMM;
          default:      return osd_pkg::OSD_EA_NONE;
        endcase
      end
      default: return osd_pkg::OSD_EA_NONE;
    endcase
  endfunction : osd_ea_dec

  // Places a mode into its usage categories.
  function automatic osd_pkg::osd_class_t osd_ea_cls(input osd_pkg::osd_ea_t m);
    osd_pkg::osd_class_t c;
    c.data      = (m != osd_pkg::OSD_EA_AREG) && (m != osd_pkg::OSD_EA_NONE);
    c.memory    = (m != osd_pkg::OSD_EA_DREG) && (m != osd_pkg::OSD_EA_AREG)
                  && (m != osd_pkg::OSD_EA_NONE);
    c.control   = c.memory && (m != osd_pkg::OSD_EA_POST)
                  && (m != osd_pkg::OSD_EA_PRE) && (m != osd_pkg::OSD_EA_IMM);
    c.alterable = (m <= osd_pkg::OSD_EA_IDX);
    c.alt_mem   = c.alterable && c.memory;
    c.data_alt  = c.alterable && c.data;
    return c;
  endfunction : osd_ea_cls

  // Register file: port A reads the source, port B the old destination.
  osd_regfile #(
    .DW (32),
    .AW (4)
  ) u_regfile (
    .i_clk_sys (i_clk_sys),
    .i_we      (rf_we),
    .i_waddr   ({st_q.req.dst_is_addr, st_q.req.dst_num}),
    .i_wdata   (wr_val),
    .i_ra      ({i_req.src_is_addr, i_req.src_num}),
    .i_rb      ({i_req.dst_is_addr, i_req.dst_num}),
    .o_qa      (qa),
    .o_qb      (qb)
  );

  // Decode of the captured request, evaluated while it executes.
  always_comb
  begin
    sz      = osd_pick_size(st_q.req.size_expl, st_q.req.size_code,
                            st_q.req.size_impl);
    sz_ok   = !(st_q.req.size_expl && (st_q.req.size_code == `OSD_SZ_RSVD));
    ea      = osd_ea_dec(st_q.req.ea_mode, st_q.req.ea_reg);
    cls     = osd_ea_cls(ea);
    illegal = !sz_ok || (ea == osd_pkg::OSD_EA_NONE);
    // Byte operations never reach an address register.
    if ((sz == osd_pkg::OSD_BYTE) && ((st_q.req.src_is_reg && st_q.req.src_is_addr)
        || (st_q.req.dst_wr && st_q.req.dst_is_addr) || (ea == osd_pkg::OSD_EA_AREG)))
    begin
      illegal = 1'b1;
    end
  end

  // Operand sizing and write merging.
  always_comb
  begin
    src_raw = st_q.req.src_is_reg ? qa : st_q.req.src_val;
    case (sz)
      osd_pkg::OSD_BIT:  src_sz = {31'h0000_0000, src_raw[0]};
      osd_pkg::OSD_BYTE: src_sz = {24'h00_0000, src_raw[`OSD_MSB_BYTE:0]};
      osd_pkg::OSD_WORD:
      begin
        // A word headed for an address register is widened by its sign.
        if (st_q.req.dst_is_addr)
        begin
          src_sz = {{(`OSD_MSB_LONG - `OSD_MSB_WORD){src_raw[`OSD_MSB_WORD]}},
                    src_raw[`OSD_MSB_WORD:0]};
        end
        else
        begin
          src_sz = {16'h0000, src_raw[`OSD_MSB_WORD:0]};
        end
      end
      osd_pkg::OSD_LONG: src_sz = src_raw;
      default:           src_sz = src_raw;
    endcase
    wr_val = qb;
    if (st_q.req.dst_is_addr)
    begin
      wr_val = src_sz;
    end
    else
    begin
      case (sz)
        osd_pkg::OSD_BIT:  wr_val[st_q.req.bit_pos] = src_raw[0];
        osd_pkg::OSD_BYTE: wr_val[`OSD_MSB_BYTE:0] = src_raw[`OSD_MSB_BYTE:0];
        osd_pkg::OSD_WORD: wr_val[`OSD_MSB_WORD:0] = src_raw[`OSD_MSB_WORD:0];
        osd_pkg::OSD_LONG: wr_val = src_raw;
        default:           wr_val = qb;
      endcase
    end
    rf_we = (st_q.fsm == osd_pkg::OSD_ST_EXEC) && st_q.req.dst_wr
            && !illegal && !st_q.req.sr_acc;
  end

  // Status word access; only implemented bits are ever stored.
  always_comb
  begin
    sr_rd  = st_q.req.sr_ccr ? {8'h00, st_q.sr[7:0]} : st_q.sr;
    sr_new = st_q.sr;
    if (st_q.req.sr_wr)
    begin
      // User mode reaches only the low byte, as does any condition-code write.
      if (st_q.req.sr_ccr || !st_q.req.supervisor)
      begin
        sr_new = {st_q.sr[15:8], st_q.req.src_val[7:0]} & `OSD_SR_MASK;
      end
      else
      begin
        sr_new = st_q.req.src_val[15:0] & `OSD_SR_MASK;
      end
    end
  end

  // Big-endian byte lanes: lane k is the byte at address N plus k.
  always_comb
  begin
    case (sz)
      osd_pkg::OSD_LONG: nbytes = 3'h4;
      osd_pkg::OSD_WORD: nbytes = 3'h2;
      default:           nbytes = 3'h1;
    endcase
    shamt   = {2'(3'h4 - nbytes), 3'h0};
    aligned = src_sz << shamt;
  end

  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++)
    begin : g_lane
      // The most significant byte lands at the lowest address.
      assign lanes[gk] = aligned[`OSD_MSB_LONG - 8*gk -: 8];
    end
  endgenerate

  // Answer assembled from the executing request.
  always_comb
  begin
    rsp           = '0;
    rsp.valid     = 1'b1;
    rsp.ea        = ea;
    rsp.cls       = cls;
    rsp.illegal   = st_q.req.sr_acc ? 1'b0 : illegal;
    rsp.size      = st_q.req.sr_acc ? osd_pkg::OSD_WORD : sz;
    rsp.result    = st_q.req.sr_acc ? {16'h0000, sr_rd} : src_sz;
    rsp.mem_bytes = lanes;
    rsp.byte_cnt  = st_q.req.sr_acc ? 3'h2 : nbytes;
    rsp.sr_rdata  = sr_rd;
  end

  // Next-state logic: take a request, then execute it for one cycle.
  always_comb
  begin
    st_d            = st_q;
    st_d.resp.valid = 1'b0;
    case (st_q.fsm)
      osd_pkg::OSD_ST_IDLE:
      begin
        if (i_req.valid)
        begin
          st_d.req  = i_req;
          st_d.busy = 1'b1;
          st_d.fsm  = osd_pkg::OSD_ST_EXEC;
        end
      end
      osd_pkg::OSD_ST_EXEC:
      begin
        st_d.resp = rsp;
        st_d.busy = 1'b0;
        st_d.fsm  = osd_pkg::OSD_ST_IDLE;
        if (st_q.req.sr_acc)
        begin
          st_d.sr = sr_new;
        end
      end
      default:
      begin
        st_d.fsm  = osd_pkg::OSD_ST_IDLE;
        st_d.busy = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st_q     <= '0;
      st_q.fsm <= osd_pkg::OSD_ST_IDLE;
      st_q.sr  <= `OSD_SR_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign o_resp = st_q.resp;
  assign o_busy = st_q.busy;
  assign o_sr   = st_q.sr;

  // Checks on answer timing, sizing and merging.
  a_resp_timing: assert property (i_req.valid && !o_busy |-> ##2 o_resp.valid)
    else $error("answer did not follow two cycles after a taken request");

  a_size_implicit: assert property (o_resp.valid && !st_q.req.sr_acc
      && !st_q.req.size_expl |-> o_resp.size == st_q.req.size_impl)
    else $error("implicit size not used");

  a_long_full: assert property (rf_we && !st_q.req.dst_is_addr
      && sz == osd_pkg::OSD_LONG |-> wr_val == src_raw)
    else $error("longword write did not update all bits");

  a_word_merge: assert property (rf_we && !st_q.req.dst_is_addr
      && sz == osd_pkg::OSD_WORD |-> wr_val[31:16] == qb[31:16]
      && wr_val[15:0] == src_raw[15:0])
    else $error("word write disturbed upper half");

  a_byte_merge: assert property (rf_we && !st_q.req.dst_is_addr
      && sz == osd_pkg::OSD_BYTE |-> wr_val[31:8] == qb[31:8])
    else $error("byte write disturbed upper bits");

  a_byte_addr: assert property (st_q.fsm == osd_pkg::OSD_ST_EXEC && !st_q.req.sr_acc
      && st_q.req.dst_wr && st_q.req.dst_is_addr
      && sz == osd_pkg::OSD_BYTE |=> o_resp.illegal && !$past(rf_we))
    else $error("byte access to address register accepted");

  a_addr_word: assert property (rf_we && st_q.req.dst_is_addr
      && sz == osd_pkg::OSD_WORD |-> wr_val == {{16{src_raw[15]}}, src_raw[15:0]})
    else $error("address word not sign-extended");

  // Checks on the status word.
  a_sr_clean: assert property ((o_sr & ~`OSD_SR_MASK) == 16'h0000)
    else $error("reserved status bit set");

  a_sr_word: assert property (o_resp.valid && st_q.req.sr_acc
      |-> o_resp.size == osd_pkg::OSD_WORD && o_resp.byte_cnt == 3'h2)
    else $error("status access not word-size");

  a_ccr_upper: assert property (o_resp.valid && st_q.req.sr_acc && st_q.req.sr_ccr
      |-> o_resp.sr_rdata[15:8] == 8'h00 && o_sr[15:8] == $past(o_sr[15:8]))
    else $error("condition-code upper byte leaked");

  // Checks on memory byte order.
  a_be_long: assert property (o_resp.valid && o_resp.size == osd_pkg::OSD_LONG
      |-> o_resp.mem_bytes[0] == o_resp.result[31:24]
      && o_resp.mem_bytes[2] == o_resp.result[15:8])
    else $error("longword byte order wrong");

  a_be_word: assert property (o_resp.valid && !st_q.req.sr_acc
      && o_resp.size == osd_pkg::OSD_WORD
      |-> o_resp.mem_bytes[0] == o_resp.result[15:8]
      && o_resp.mem_bytes[1] == o_resp.result[7:0])
    else $error("word byte order wrong");

  // Checks on address-mode decoding.
  a_ea_dreg: assert property (o_resp.valid && st_q.req.ea_mode == `OSD_M_DREG
      |-> o_resp.ea == osd_pkg::OSD_EA_DREG && !o_resp.cls.memory)
    else $error("data register direct misdecoded");

  a_ea_index: assert property (o_resp.valid && st_q.req.ea_mode == `OSD_M_IDX
      |-> o_resp.ea == osd_pkg::OSD_EA_IDX && o_resp.cls.alt_mem)
    else $error("scaled index mode misdecoded");

  a_ea_imm: assert property (o_resp.valid && st_q.req.ea_mode == `OSD_M_EXT
      && st_q.req.ea_reg == `OSD_X_IMM |-> o_resp.ea == osd_pkg::OSD_EA_IMM
      && !o_resp.cls.control && !o_resp.cls.alterable)
    else $error("immediate mode misdecoded");

  // Combined categories are checked against the mode itself, not the other bits.
  a_cls_combo: assert property (o_resp.valid |-> o_resp.cls.data_alt
      == (o_resp.ea inside {osd_pkg::OSD_EA_DREG, osd_pkg::OSD_EA_IND, osd_pkg::OSD_EA_POST,
      osd_pkg::OSD_EA_PRE, osd_pkg::OSD_EA_D16, osd_pkg::OSD_EA_IDX})
      && o_resp.cls.alt_mem == (o_resp.ea inside {osd_pkg::OSD_EA_IND, osd_pkg::OSD_EA_POST,
      osd_pkg::OSD_EA_PRE, osd_pkg::OSD_EA_D16, osd_pkg::OSD_EA_IDX}))
    else $error("combined category wrong");

  a_cls_areg: assert property (o_resp.valid && o_resp.ea == osd_pkg::OSD_EA_AREG
      |-> !o_resp.cls.data && o_resp.cls.alterable)
    else $error("address direct category wrong");

  a_ea_bad: assert property (o_resp.valid && !st_q.req.sr_acc
      && st_q.req.ea_mode == `OSD_M_EXT && st_q.req.ea_reg > `OSD_X_IMM
      |-> o_resp.illegal)
    else $error("undefined extended mode accepted");

endmodule : osd_decoder

// ===== pkg/osd_defines.svh
`ifndef OSD_DEFINES_SVH
`define OSD_DEFINES_SVH

// Explicit size encodings carried in the instruction.
`define OSD_SZ_BYTE 2'h0
`define OSD_SZ_WORD 2'h1
`define OSD_SZ_LONG 2'h2
`define OSD_SZ_RSVD 2'h3

// Most significant bit of each integer size.
`define OSD_MSB_BYTE 7
`define OSD_MSB_WORD 15
`define OSD_MSB_LONG 31

// Effective-address mode field values.
`define OSD_M_DREG 3'h0
`define OSD_M_AREG 3'h1
`define OSD_M_IND  3'h2
`define OSD_M_POST 3'h3
`define OSD_M_PRE  3'h4
`define OSD_M_D16  3'h5
`define OSD_M_IDX  3'h6
`define OSD_M_EXT  3'h7

// Register field values under the extended mode.
`define OSD_X_ABSW  3'h0
`define OSD_X_ABSL  3'h1
`define OSD_X_PCD16 3'h2
`define OSD_X_PCIDX 3'h3
`define OSD_X_IMM   3'h4

// Status word reset value and implemented bits.
`define OSD_SR_RESET 16'h2700
`define OSD_SR_MASK  16'hB71F

`endif

// ===== pkg/osd_pkg.sv
package osd_pkg;

  typedef enum logic [1:0] {OSD_BIT, OSD_BYTE, OSD_WORD, OSD_LONG} osd_size_t;

  typedef enum logic [3:0] {
    OSD_EA_DREG, OSD_EA_AREG, OSD_EA_IND, OSD_EA_POST, OSD_EA_PRE,
    OSD_EA_D16, OSD_EA_IDX, OSD_EA_PCD16, OSD_EA_PCIDX, OSD_EA_ABSW,
    OSD_EA_ABSL, OSD_EA_IMM, OSD_EA_NONE
  } osd_ea_t;

  typedef enum logic {OSD_ST_IDLE, OSD_ST_EXEC} osd_state_t;

  typedef struct packed {
    logic data;
    logic memory;
    logic control;
    logic alterable;
    logic alt_mem;
    logic data_alt;
  } osd_class_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  ea_mode;
    logic [2:0]  ea_reg;
    logic        size_expl;
    logic [1:0]  size_code;
    osd_size_t   size_impl;
    logic [31:0] src_val;
    logic        src_is_reg;
    logic        src_is_addr;
    logic [2:0]  src_num;
    logic        dst_wr;
    logic        dst_is_addr;
    logic [2:0]  dst_num;
    logic [4:0]  bit_pos;
    logic        sr_acc;
    logic        sr_ccr;
    logic        sr_wr;
    logic        supervisor;
  } osd_req_t;

  typedef struct packed {
    logic            valid;
    logic            illegal;
    osd_ea_t         ea;
    osd_class_t      cls;
    osd_size_t       size;
    logic [31:0]     result;
    logic [3:0][7:0] mem_bytes;
    logic [2:0]      byte_cnt;
    logic [15:0]     sr_rdata;
  } osd_resp_t;

  typedef struct packed {
    osd_state_t  fsm;
    logic        busy;
    osd_req_t    req;
    osd_resp_t   resp;
    logic [15:0] sr;
  } osd_regs_t;

endpackage : osd_pkg

// ===== design/osd_regfile.sv
// Eight data and eight address registers, two registered read ports.
module osd_regfile #(
  parameter int DW = 32,
  parameter int AW = 4
) (
  // Clock.
  input  wire logic          i_clk_sys,
  // Write port.
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read ports.
  input  wire logic [AW-1:0] i_ra,
  input  wire logic [AW-1:0] i_rb,
  output      logic [DW-1:0] o_qa,
  output      logic [DW-1:0] o_qb
);

  logic [DW-1:0] mem [2**AW];

  // Register contents are data, not control, so they carry no reset.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_qa <= mem[i_ra];
    o_qb <= mem[i_rb];
  end

endmodule : osd_regfile

// ===== tb/osd_mem_model.sv
// Operand memory seen by the block: a byte array read as a longword.
module osd_mem_model (
  // Byte address of the operand.
  input  wire logic [7:0]  i_addr,
  // Four bytes from the address upward.
  output      logic [31:0] o_long
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_q [256];

  // A fixed pattern lets the bench predict every byte without reading the array.
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_q[i] = 8'(i * 37 + 5);
  end

  // The lowest address lands in the most significant byte.
  assign o_long = {mem_q[i_addr], mem_q[8'(i_addr + 1)],
                   mem_q[8'(i_addr + 2)], mem_q[8'(i_addr + 3)]};
endmodule : osd_mem_model

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

  logic               i_clk_sys   = 1'b0;
  logic               i_rst       = 1'b1;
  osd_pkg::osd_req_t  req         = '0;
  osd_pkg::osd_resp_t resp;
  logic               busy;
  logic [15:0]        stat;
  logic [7:0]         mem_addr    = 8'h00;
  logic [31:0]        mem_long;
  logic [31:0]        m_reg [16];
  logic [15:0]        m_stat      = 16'h2700;
  logic [31:0]        seed        = 32'h0000_4779;
  logic               hog         = 1'b0;
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 cycles      = 0;

  // Free-running system clock.
  always #20 i_clk_sys = ~i_clk_sys;

  osd_decoder dut (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_req     (req),
    .o_resp    (resp),
    .o_busy    (busy),
    .o_sr      (stat)
  );

  osd_mem_model mem (
    .i_addr (mem_addr),
    .o_long (mem_long)
  );

  // Random source for operands and bit positions.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Mode decode as the bench expects it.
  function automatic osd_pkg::osd_ea_t ea_of(input logic [2:0] m, input logic [2:0] g);
    if (m != 3'h7)
      return osd_pkg::osd_ea_t'(m);
    case (g)
      3'h0:    return osd_pkg::OSD_EA_ABSW;
      3'h1:    return osd_pkg::OSD_EA_ABSL;
      3'h2:    return osd_pkg::OSD_EA_PCD16;
      3'h3:    return osd_pkg::OSD_EA_PCIDX;
      3'h4:    return osd_pkg::OSD_EA_IMM;
      default: return osd_pkg::OSD_EA_NONE;
    endcase
  endfunction : ea_of

  // Category bits; an undefined mode belongs to no category.
  function automatic osd_pkg::osd_class_t cls_of(input osd_pkg::osd_ea_t e);
    osd_pkg::osd_class_t c;
    c.memory    = !(e inside {osd_pkg::OSD_EA_DREG, osd_pkg::OSD_EA_AREG, osd_pkg::OSD_EA_NONE});
    c.data      = c.memory || e == osd_pkg::OSD_EA_DREG;
    c.control   = c.memory && !(e inside {osd_pkg::OSD_EA_POST, osd_pkg::OSD_EA_PRE,
                                          osd_pkg::OSD_EA_IMM});
    c.alterable = e inside {[osd_pkg::OSD_EA_DREG:osd_pkg::OSD_EA_IDX]};
    c.alt_mem   = c.alterable && c.memory;
    c.data_alt  = c.alterable && c.data;
    return c;
  endfunction : cls_of

  // One request, an optional refused request while busy, then the answer check.
  task automatic run(input osd_pkg::osd_req_t r);
    osd_pkg::osd_req_t  h;
    osd_pkg::osd_size_t sz;
    osd_pkg::osd_ea_t   ea;
    logic [31:0]        src;
    logic [31:0]        res;
    logic [3:0]         key;
    logic               ill;
    int                 cnt;
    h         = r;
    h.valid   = hog;
    h.dst_num = r.dst_num ^ 3'h1;
    h.src_val = ~r.src_val;
    @(posedge i_clk_sys);
    #2 req = r;
    @(posedge i_clk_sys);
    #2 req = h;
    // The request was taken at the last edge; the answer pulse is not up yet.
    `CHK("busy", 1'b1, busy)
    `CHK("valid early", 1'b0, resp.valid)
    @(posedge i_clk_sys);
    #2 req.valid = 1'b0;
    // The answer stands for this one cycle only, so it is checked now.
    `CHK("busy low", 1'b0, busy)
    key = {r.src_is_addr, r.src_num};
    src = r.src_is_reg ? m_reg[key] : r.src_val;
    case ({r.size_expl, r.size_code})
      3'b100:  sz = osd_pkg::OSD_BYTE;
      3'b101:  sz = osd_pkg::OSD_WORD;
      3'b110:  sz = osd_pkg::OSD_LONG;
      default: sz = r.size_expl ? osd_pkg::OSD_LONG : r.size_impl;
    endcase
    ea  = ea_of(r.ea_mode, r.ea_reg);
    ill = !r.sr_acc && (ea == osd_pkg::OSD_EA_NONE || (r.size_expl && r.size_code == 2'h3)
          || (sz == osd_pkg::OSD_BYTE && ((r.src_is_reg && r.src_is_addr)
          || (r.dst_wr && r.dst_is_addr) || ea == osd_pkg::OSD_EA_AREG)));
    case (sz)
      osd_pkg::OSD_BIT:  res = {31'h0, src[0]};
      osd_pkg::OSD_BYTE: res = {24'h0, src[7:0]};
      osd_pkg::OSD_WORD: res = {{16{r.dst_is_addr & src[15]}}, src[15:0]};
      default:           res = src;
    endcase
    cnt = (sz == osd_pkg::OSD_LONG) ? 4 : (sz == osd_pkg::OSD_WORD) ? 2 : 1;
    if (r.sr_acc)
      res = r.sr_ccr ? {24'h0, m_stat[7:0]} : {16'h0, m_stat};
    `CHK("valid", 1'b1, resp.valid)
    `CHK("illegal", ill, resp.illegal)
    `CHK("mode", ea, resp.ea)
    `CHK("class", cls_of(ea), resp.cls)
    if (!ill)
      `CHK("result", res, resp.result)
    if (!ill && !r.sr_acc)
      `CHK("size", sz, resp.size)
    if (r.sr_acc)
      `CHK("status size", osd_pkg::OSD_WORD, resp.size)
    if (r.sr_acc)
      `CHK("status read", res[15:0], resp.sr_rdata)
    if (!ill && !r.sr_acc)
      `CHK("count", 3'(cnt), resp.byte_cnt)
    for (int k = 0; k < cnt; k++)
      if (!ill && !r.sr_acc && sz != osd_pkg::OSD_BIT)
        `CHK("lane", 8'(src >> (8 * (cnt - 1 - k))), resp.mem_bytes[k])
    // The model updates only after the answer, since reads see the old state.
    key = {r.dst_is_addr, r.dst_num};
    if (r.sr_acc && r.sr_wr)
      m_stat = (r.sr_ccr || !r.supervisor) ? {m_stat[15:8], r.src_val[7:0] & 8'h1F}
               : r.src_val[15:0] & 16'hB71F;
    else if (r.dst_wr && !ill && r.dst_is_addr)
      m_reg[key] = res;
    else if (r.dst_wr && !ill && sz == osd_pkg::OSD_BYTE)
      m_reg[key][7:0] = res[7:0];
    else if (r.dst_wr && !ill && sz == osd_pkg::OSD_WORD)
      m_reg[key][15:0] = res[15:0];
    else if (r.dst_wr && !ill && sz == osd_pkg::OSD_BIT)
      m_reg[key][r.bit_pos] = res[0];
    else if (r.dst_wr && !ill)
      m_reg[key] = res;
    `CHK("status word", m_stat, stat)
  endtask : run

  // Reads a register back as a full longword source.
  task automatic rd(input osd_pkg::osd_req_t b, input logic a, input logic [2:0] n);
    b.src_is_reg  = 1'b1;
    b.src_is_addr = a;
    b.src_num     = n;
    run(b);
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // A hang is cut short well past the roughly nine hundred cycles the sequence needs.
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      conclude();
    end
  end

  // Main sequence.
  initial
  begin
    osd_pkg::osd_req_t b;
    osd_pkg::osd_req_t r;
    b           = '0;
    b.valid     = 1'b1;
    b.size_expl = 1'b1;
    b.size_code = 2'h2;
    repeat (8) @(posedge i_clk_sys);
    #2 i_rst = 1'b0;
    `CHK("reset status", 16'h2700, stat)
    // Every mode pair; longword passes load all registers, byte passes write nothing.
    for (int i = 0; i < 128; i++)
    begin
      r             = b;
      r.size_code   = i[6] ? 2'h0 : 2'h2;
      r.ea_mode     = i[5:3];
      r.ea_reg      = i[2:0];
      r.src_val     = rnd();
      r.dst_wr      = !i[6];
      r.dst_is_addr = i[3];
      r.dst_num     = i[2:0];
      run(r);
    end
    // Merging writes of every size, some with a refused request while busy.
    for (int i = 0; i < 48; i++)
    begin
      r             = b;
      r.size_expl   = (i % 4) != 3;
      r.size_code   = 2'(i % 3);
      r.size_impl   = osd_pkg::osd_size_t'(i / 4 % 4);
      r.src_val     = rnd();
      r.bit_pos     = 5'(rnd());
      r.src_is_reg  = i[3];
      r.src_is_addr = i[5] && r.size_expl;
      r.src_num     = 3'(i + 3);
      r.dst_wr      = 1'b1;
      r.dst_is_addr = i[4] && r.size_expl;
      r.dst_num     = 3'(i);
      hog           = i[1];
      run(r);
      hog           = 1'b0;
      rd(b, r.dst_is_addr, r.dst_num);
      rd(b, r.dst_is_addr, r.dst_num ^ 3'h1);
    end
    // Reserved size code is refused and leaves the register alone.
    r             = b;
    r.size_code   = 2'h3;
    r.dst_wr      = 1'b1;
    run(r);
    rd(b, 1'b0, 3'h0);
    // Operands fetched from memory keep their byte order in the lanes.
    for (int i = 0; i < 9; i++)
    begin
      mem_addr = 8'(rnd());
      #1;
      r           = b;
      r.size_code = 2'(i % 3);
      r.src_val   = mem_long >> ((i % 3 == 0) ? 24 : (i % 3 == 1) ? 16 : 0);
      run(r);
      `CHK("lane at N", 8'(mem_addr * 37 + 5), resp.mem_bytes[0])
    end
    // Status and condition-code reads in supervisor mode, and writes in both privilege levels.
    for (int i = 0; i < 16; i++)
    begin
      r            = b;
      r.sr_acc     = 1'b1;
      r.sr_ccr     = i[0];
      r.sr_wr      = i[1];
      r.supervisor = i[2] | ~i[1];
      r.src_val    = (i == 6) ? 32'h0000_FFFF : rnd();
      run(r);
    end
    conclude();
  end
endmodule : tb_top
